// ==== rtl/dbm_channel.sv ====
`timescale 1ns/1ps
`include "dbm_cfg.svh"
// Functional notes
// - Unspread rate is clock over 27 times divider
// - Spread rate is clock/33 times (1+offset/512)
// - Check bits follow the last data bit
// - Length, polynomial, seed come from fields
// - Received check mismatch sets error flag
// - Default is 4-bit, x^4+1, pattern 1010
// - Silent bus gives zeros, checked as configured
// - Interrupt line only ever pulled low
// - Reset restores register defaults and halts bus
// - Channel selects spread or divided clock
// - Four received responses, oldest read first
// - Receive queue filling raises interrupt
// - Four transmit words sent in order
// - Transmit queue emptying raises interrupt
// - Bus driven only while channel enabled
// - Only data low access pops receive queue
// - Bit starts low, one third or two thirds
// - Each bit is three bit-clock cycles
module dbm_channel #(
  parameter int DEPTH = 4,
  parameter logic [7:0] GAP_THIRDS = `DBM_GAP_THIRDS
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [7:0] wb_adr,
  input wire logic [31:0] wb_dat_w,
  output logic [31:0] wb_dat_r,
  input wire logic [3:0] wb_sel,
  input wire logic wb_we,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  output logic wb_ack,
  output logic bus_frame_n,
  output logic bus_sig,
  input wire logic bus_ret,
  output logic bus_en,
  output logic irq_drive,
  output logic irq_oe
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic en;
    logic ie_rx;
    logic ie_tx;
    logic spread;
    logic [3:0] div;
    logic [3:0] clen;
    logic [3:0] wl8;
    logic [7:0] poly;
    logic [7:0] seed;
    logic [7:0] offs;
    logic [7:0] dhigh;
    logic [DEPTH-1:0][15:0] txq;
    logic [PW-1:0] tx_wp;
    logic [PW-1:0] tx_rp;
    logic [CW-1:0] tx_cnt;
    dbm_pkg::dbm_rxe_s [DEPTH-1:0] rxq;
    logic [PW-1:0] rx_wp;
    logic [PW-1:0] rx_rp;
    logic [CW-1:0] rx_cnt;
    logic [15:0] acc;
    dbm_pkg::dbm_phase_e phase;
    logic [1:0] third;
    logic [4:0] bitp;
    logic [15:0] shf;
    logic [7:0] tcrc;
    logic [7:0] rcrc;
    logic [15:0] rdat;
    logic rerr;
    logic [7:0] gap;
    logic frame_n;
    logic sig;
    logic bus_en;
    logic irq_rxp;
    logic irq_txp;
    logic irq_oe;
    logic irq_drive;
    logic ack;
    logic [31:0] rdata;
  } dbm_state_s;

  dbm_state_s st_r;
  dbm_state_s st_nxt;

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction

  // A length of eight selects bit 7 through the 3-bit wrap
  function automatic logic crc_msb(input logic [7:0] c,
                                   input logic [3:0] len);
    crc_msb = (len == 4'h0) ? 1'b0 : c[len[2:0] - 3'h1];
  endfunction

  function automatic logic [7:0] crc_step(input logic [7:0] c,
                                          input logic b,
                                          input logic [7:0] poly,
                                          input logic [3:0] len);
    logic [7:0] mask;
    logic fb;
    mask = 8'((9'h001 << len) - 9'h001);
    fb = b ^ crc_msb(c, len);
    crc_step = ((c << 1) ^ (fb ? poly : 8'h00)) & mask;
  endfunction

  function automatic logic [3:0] clamp8(input logic [3:0] v);
    clamp8 = (v > `DBM_CHK_MAX) ? `DBM_CHK_MAX : v;
  endfunction

  always_comb begin
    logic hit;
    logic wr;
    logic abort;
    logic tick;
    logic cur;
    logic push;
    logic pop;
    logic txpush;
    logic rxpop;
    logic [15:0] lim;
    dbm_pkg::dbm_rxe_s head;
    st_nxt = st_r;
    hit = wb_cyc & wb_stb & ~st_r.ack;
    wr = hit & wb_we & wb_sel[0];
    abort = 1'b0;
    tick = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    txpush = 1'b0;
    rxpop = 1'b0;
    cur = 1'b0;
    lim = 16'h0000;
    head = st_r.rxq[st_r.rx_rp];
    st_nxt.ack = hit;
    st_nxt.rdata = 32'h0000_0000;

    // Register decode; control, length, polynomial and seed writes abort a frame in flight
    if (wb_adr == `DBM_OFS_CTRL) begin
      st_nxt.rdata[`DBM_CTRL_EN] = st_r.en;
      st_nxt.rdata[`DBM_CTRL_IRX] = st_r.ie_rx;
      st_nxt.rdata[`DBM_CTRL_ITX] = st_r.ie_tx;
      st_nxt.rdata[`DBM_CTRL_SS] = st_r.spread;
      st_nxt.rdata[`DBM_CTRL_DIV] = st_r.div;
      if (wr) begin
        st_nxt.en = wb_dat_w[`DBM_CTRL_EN];
        st_nxt.ie_rx = wb_dat_w[`DBM_CTRL_IRX];
        st_nxt.ie_tx = wb_dat_w[`DBM_CTRL_ITX];
        st_nxt.spread = wb_dat_w[`DBM_CTRL_SS];
        st_nxt.div = wb_dat_w[`DBM_CTRL_DIV];
        abort = 1'b1;
      end
    end else if (wb_adr == `DBM_OFS_LEN) begin
      st_nxt.rdata[`DBM_LEN_CHK] = st_r.clen;
      st_nxt.rdata[`DBM_LEN_WRD] = st_r.wl8;
      if (wr) begin
        st_nxt.clen = clamp8(wb_dat_w[`DBM_LEN_CHK]);
        st_nxt.wl8 = clamp8(wb_dat_w[`DBM_LEN_WRD]);
        abort = 1'b1;
      end
    end else if (wb_adr == `DBM_OFS_POLY) begin
      st_nxt.rdata[7:0] = st_r.poly;
      if (wr) begin
        st_nxt.poly = wb_dat_w[7:0];
        abort = 1'b1;
      end
    end else if (wb_adr == `DBM_OFS_SEED) begin
      st_nxt.rdata[7:0] = st_r.seed;
      if (wr) begin
        st_nxt.seed = wb_dat_w[7:0];
        abort = 1'b1;
      end
    end else if (wb_adr == `DBM_OFS_OFFS) begin
      st_nxt.rdata[7:0] = st_r.offs;
      if (wr) begin
        st_nxt.offs = wb_dat_w[7:0];
      end
    end else if (wb_adr == `DBM_OFS_DHI) begin
      st_nxt.rdata[7:0] = head.data[15:8];
      if (wr) begin
        st_nxt.dhigh = wb_dat_w[7:0];
      end
    end else if (wb_adr == `DBM_OFS_DLO) begin
      st_nxt.rdata[7:0] = head.data[7:0];
      rxpop = hit && (st_r.rx_cnt != '0);
      if (wr && (st_r.tx_cnt < CW'(DEPTH))) begin
        txpush = 1'b1;
        st_nxt.txq[st_r.tx_wp] = {st_r.dhigh, wb_dat_w[7:0]};
        st_nxt.tx_wp = ptr_inc(st_r.tx_wp);
      end
    end else if (wb_adr == `DBM_OFS_STAT) begin
      st_nxt.rdata[`DBM_ST_RXNE] = (st_r.rx_cnt != '0);
      st_nxt.rdata[`DBM_ST_TXNF] = (st_r.tx_cnt < CW'(DEPTH));
      st_nxt.rdata[`DBM_ST_TXE] = (st_r.tx_cnt == '0);
      st_nxt.rdata[`DBM_ST_ERR] = head.err;
      st_nxt.rdata[`DBM_ST_PRX] = st_r.irq_rxp;
      st_nxt.rdata[`DBM_ST_PTX] = st_r.irq_txp;
      if (hit) begin
        st_nxt.irq_rxp = 1'b0;
        st_nxt.irq_txp = 1'b0;
      end
    end

    if (rxpop) begin
      st_nxt.rx_rp = ptr_inc(st_r.rx_rp);
    end

    // Third-of-bit tick; spread mode averages a fractional period
    if (st_r.spread) begin
      lim = 16'(`DBM_SS_DIV / `DBM_THIRDS * `DBM_SS_SCALE);
      st_nxt.acc = st_r.acc + 16'(`DBM_SS_SCALE) + {8'h00, st_r.offs};
      if (st_nxt.acc >= lim) begin
        tick = 1'b1;
        st_nxt.acc = st_nxt.acc - lim;
      end
    end else begin
      lim = 16'(`DBM_DIV_BASE / `DBM_THIRDS)
          * {12'h000, (st_r.div == 4'h0) ? 4'h1 : st_r.div};
      st_nxt.acc = st_r.acc + 16'h0001;
      if (st_nxt.acc >= lim) begin
        tick = 1'b1;
        st_nxt.acc = 16'h0000;
      end
    end

    cur = (st_r.bitp > {1'b0, st_r.clen}) ? st_r.shf[15]
        : crc_msb(st_r.tcrc, st_r.clen);

    case (st_r.phase)
      dbm_pkg::ph_idle: begin
        if (tick && (st_r.gap != 8'h00)) begin
          st_nxt.gap = st_r.gap - 8'h01;
        end
        // A config write in this cycle would start a whole frame on the old settings, unseen by the abort
        if (tick && st_r.en && !abort && (st_r.tx_cnt != '0)
            && (st_r.gap == 8'h00)) begin
          st_nxt.phase = dbm_pkg::ph_lead;
          st_nxt.frame_n = 1'b0;
          st_nxt.third = 2'h0;
          st_nxt.bitp = 5'(st_r.wl8) + 5'h08 + 5'(st_r.clen);
          st_nxt.shf = st_r.txq[st_r.tx_rp] << (4'h8 - st_r.wl8);
          st_nxt.tcrc = st_r.seed;
          st_nxt.rcrc = st_r.seed;
          st_nxt.rdat = 16'h0000;
          st_nxt.rerr = 1'b0;
        end
      end
      dbm_pkg::ph_lead: begin
        if (tick) begin
          st_nxt.third = st_r.third + 2'h1;
          if (st_r.third == 2'h2) begin
            st_nxt.phase = dbm_pkg::ph_xfer;
            st_nxt.third = 2'h0;
            st_nxt.sig = 1'b0;
          end
        end
      end
      dbm_pkg::ph_xfer: begin
        if (tick) begin
          st_nxt.third = st_r.third + 2'h1;
          if (st_r.third == 2'h0) begin
            st_nxt.sig = cur;
          end else if (st_r.third == 2'h1) begin
            st_nxt.sig = 1'b1;
          end else begin
            if (st_r.bitp > {1'b0, st_r.clen}) begin
              st_nxt.shf = st_r.shf << 1;
              st_nxt.tcrc = crc_step(st_r.tcrc, st_r.shf[15],
                                     st_r.poly, st_r.clen);
              st_nxt.rcrc = crc_step(st_r.rcrc, bus_ret,
                                     st_r.poly, st_r.clen);
              st_nxt.rdat = {st_r.rdat[14:0], bus_ret};
            end else begin
              st_nxt.tcrc = st_r.tcrc << 1;
              st_nxt.rcrc = st_r.rcrc << 1;
              if (bus_ret != crc_msb(st_r.rcrc, st_r.clen)) begin
                st_nxt.rerr = 1'b1;
              end
            end
            st_nxt.bitp = st_r.bitp - 5'h01;
            st_nxt.third = 2'h0;
            st_nxt.sig = 1'b0;
            if (st_r.bitp == 5'h01) begin
              st_nxt.phase = dbm_pkg::ph_rpush;
              st_nxt.frame_n = 1'b1;
              st_nxt.sig = 1'b1;
              st_nxt.gap = GAP_THIRDS;
            end
          end
        end
      end
      dbm_pkg::ph_rpush: begin
        // Error flag is final here, before any pointer moves
        push = (st_r.rx_cnt < CW'(DEPTH)) || rxpop;
        if (push) begin
          st_nxt.rxq[st_r.rx_wp] = '{err: st_r.rerr && (st_r.clen != 4'h0),
                                     data: st_r.rdat};
          st_nxt.rx_wp = ptr_inc(st_r.rx_wp);
        end
        st_nxt.phase = dbm_pkg::ph_xpop;
      end
      dbm_pkg::ph_xpop: begin
        pop = 1'b1;
        st_nxt.tx_rp = ptr_inc(st_r.tx_rp);
        st_nxt.phase = dbm_pkg::ph_idle;
      end
      default: begin
        st_nxt.phase = dbm_pkg::ph_idle;
      end
    endcase

    if ((abort || !st_r.en) && ((st_r.phase == dbm_pkg::ph_lead)
        || (st_r.phase == dbm_pkg::ph_xfer))) begin
      st_nxt.phase = dbm_pkg::ph_idle;
      st_nxt.frame_n = 1'b1;
      st_nxt.sig = 1'b1;
    end

    st_nxt.rx_cnt = st_r.rx_cnt + CW'(push) - CW'(rxpop);
    st_nxt.tx_cnt = st_r.tx_cnt + CW'(txpush) - CW'(pop);
    // Set wins over a status read in the same cycle
    if (push && (st_r.rx_cnt == '0 || (st_r.rx_cnt == CW'(1) && rxpop))) begin
      st_nxt.irq_rxp = 1'b1;
    end
    if (pop && (st_r.tx_cnt == CW'(1)) && !txpush) begin
      st_nxt.irq_txp = 1'b1;
    end
    st_nxt.irq_oe = (st_nxt.irq_rxp & st_nxt.ie_rx)
                  | (st_nxt.irq_txp & st_nxt.ie_tx);
    st_nxt.irq_drive = 1'b0;
    st_nxt.bus_en = st_nxt.en;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
      st_r.div <= `DBM_RST_DIV;
      st_r.clen <= `DBM_RST_CHK;
      st_r.poly <= `DBM_RST_POLY;
      st_r.seed <= `DBM_RST_SEED;
      st_r.phase <= dbm_pkg::ph_idle;
      st_r.frame_n <= 1'b1;
      st_r.sig <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign wb_ack = st_r.ack;
  assign wb_dat_r = st_r.rdata;
  assign bus_frame_n = st_r.frame_n;
  assign bus_sig = st_r.sig;
  assign bus_en = st_r.bus_en;
  assign irq_drive = st_r.irq_drive;
  assign irq_oe = st_r.irq_oe;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);

  a_frame_gated: assert property (!bus_en |-> bus_frame_n)
    else $error("frame active while channel disabled");
  a_irq_low_only: assert property (irq_oe |-> !irq_drive)
    else $error("interrupt line driven high");
  a_rx_pop_cause: assert property ((st_r.rx_cnt < $past(st_r.rx_cnt))
    |-> $past(wb_adr == `DBM_OFS_DLO && wb_cyc && wb_stb))
    else $error("receive queue popped without data low access");
  a_tx_depth: assert property (st_r.tx_cnt <= CW'(DEPTH))
    else $error("transmit queue overfilled");
  a_rx_depth: assert property (st_r.rx_cnt <= CW'(DEPTH))
    else $error("receive queue overfilled");
  a_bit_start_low: assert property ((st_r.phase == dbm_pkg::ph_xfer
    && st_r.third == 2'h0) |-> !bus_sig)
    else $error("bit does not start low");
  a_bit_end_high: assert property ((st_r.phase == dbm_pkg::ph_xfer
    && st_r.third == 2'h2) |-> bus_sig)
    else $error("bit does not end high");
  a_irq_rx_fill: assert property ((st_r.rx_cnt == '0 && st_r.ie_rx)
    ##1 (st_r.rx_cnt != '0 && st_r.ie_rx) |-> irq_oe)
    else $error("no interrupt on receive fill");
  a_no_check_err: assert property ((st_r.phase == dbm_pkg::ph_rpush
    && st_r.clen == 4'h0 && st_r.rx_cnt == '0)
    |=> !st_r.rxq[$past(st_r.rx_wp)].err)
    else $error("error flagged with zero check length");
endmodule // dbm_channel

// ==== rtl/dbm_cfg.svh ====
`ifndef DBM_CFG_SVH
`define DBM_CFG_SVH
// Register byte offsets
`define DBM_OFS_CTRL 8'h00
`define DBM_OFS_LEN 8'h04
`define DBM_OFS_POLY 8'h08
`define DBM_OFS_SEED 8'h0C
`define DBM_OFS_OFFS 8'h10
`define DBM_OFS_DHI 8'h14
`define DBM_OFS_DLO 8'h18
`define DBM_OFS_STAT 8'h1C
// Control fields
`define DBM_CTRL_EN 0
`define DBM_CTRL_IRX 1
`define DBM_CTRL_ITX 2
`define DBM_CTRL_SS 3
`define DBM_CTRL_DIV 7:4
// Length fields: check length, word length minus eight
`define DBM_LEN_CHK 3:0
`define DBM_LEN_WRD 7:4
// Status fields
`define DBM_ST_RXNE 0
`define DBM_ST_TXNF 1
`define DBM_ST_TXE 2
`define DBM_ST_ERR 3
`define DBM_ST_PRX 4
`define DBM_ST_PTX 5
// Reset values
`define DBM_RST_DIV 4'h1
`define DBM_RST_CHK 4'h4
`define DBM_RST_POLY 8'h01
`define DBM_RST_SEED 8'h0A
// Timing
`define DBM_DIV_BASE 27
`define DBM_SS_DIV 33
`define DBM_SS_SCALE 512
`define DBM_THIRDS 3
`define DBM_GAP_THIRDS 8'h0C
`define DBM_CHK_MAX 4'h8
`endif

// ==== rtl/dbm_pkg.sv ====
package dbm_pkg;
  typedef enum logic [5:0] {
    ph_idle = 6'h01,
    ph_lead = 6'h02,
    ph_xfer = 6'h04,
    ph_rpush = 6'h08,
    ph_xpop = 6'h10,
    ph_spare = 6'h20
  } dbm_phase_e;

  // One received response with its check result
  typedef struct packed {
    logic err;
    logic [15:0] data;
  } dbm_rxe_s;
endpackage

// ==== dv/dbm_slave_model.sv ====
`timescale 1ns/1ps
module dbm_slave_model (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic bus_frame_n,
  input wire logic bus_sig,
  input wire logic corrupt,
  input wire logic [7:0] third_cyc,
  output logic bus_ret,
  output logic [23:0] cap,
  output logic [4:0] cap_n,
  output int nfr,
  output int period
);
  logic [23:0] cur, resp;
  logic [4:0] idx, rn;
  logic sig_q, frm_q;
  int low, since;
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      {cur, resp, idx, rn, cap, cap_n, nfr, period, low, since} <= '0;
      {sig_q, frm_q, bus_ret} <= 3'b110;
    end else begin
      sig_q <= bus_sig;
      frm_q <= bus_frame_n;
      since <= since + 1;
      if (!bus_sig) low <= low + 1;
      if (bus_frame_n) begin
        // Released line wanders so a late sample cannot match by luck
        bus_ret <= ~bus_ret;
        idx <= '0;
      end else if (sig_q && !bus_sig) begin
        if (idx != 0) period <= since;
        since <= 1;
        low <= 1;
        idx <= idx + 5'd1;
        // Echo of the previous frame; nothing before the first
        bus_ret <= (rn > idx) ? resp[rn - idx - 5'd1] ^
                   (corrupt && rn == idx + 5'd1) : 1'b0;
      end else if (!sig_q && bus_sig) begin
        cur <= {cur[22:0], low * 2 < third_cyc * 3};
      end
      if (bus_frame_n && !frm_q) begin
        {cap, resp, cap_n, rn} <= {cur, cur, idx, idx};
        nfr <= nfr + 1;
        cur <= '0;
      end
    end
  end
endmodule // dbm_slave_model

// ==== dv/dual_bus_master_crc_fifo_tb.sv ====
`timescale 1ns/1ps
`include "dbm_cfg.svh"
module dual_bus_master_crc_fifo_tb;
  logic mclk, arst_n, wb_we, wb_cyc, wb_stb, wb_ack, corrupt;
  logic bus_frame_n, bus_sig, bus_ret, bus_en, irq_drive, irq_oe;
  logic [7:0] wb_adr, third_cyc, poly, seed;
  logic [31:0] wb_dat_w, wb_dat_r, rd, lfsr;
  logic [3:0] wb_sel;
  logic [23:0] cap;
  logic [4:0] cap_n;
  logic [15:0] x, y, w[5];
  int nfr, period, errors, n_tests, wl, cl, nx, t;
  logic [7:0] ra[7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h1C, 8'h20};
  logic [7:0] rv[7] = '{8'h10, 8'h04, 8'h01, 8'h0A, 8'h00, 8'h06, 8'h00};
  dbm_channel #(.DEPTH(4), .GAP_THIRDS(8'h02)) dut_u (.mclk, .arst_n,
    .wb_adr, .wb_dat_w, .wb_dat_r, .wb_sel, .wb_we, .wb_cyc, .wb_stb,
    .wb_ack, .bus_frame_n, .bus_sig, .bus_ret, .bus_en, .irq_drive,
    .irq_oe);
  dbm_slave_model slave_u (.mclk, .arst_n, .bus_frame_n, .bus_sig,
    .corrupt, .third_cyc, .bus_ret, .cap, .cap_n, .nfr, .period);
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  function automatic logic [23:0] frame(logic [15:0] d, int w, int c);
    logic [7:0] r;
    logic fb;
    r = seed;
    if (c == 0) return 24'(d);
    for (int i = w - 1; i >= 0; i--) begin
      fb = d[i] ^ r[c - 1];
      r = ((r << 1) ^ (fb ? poly : 8'h00)) & ((8'h01 << c) - 8'h01);
    end
    return (24'(d) << c) | 24'(r);
  endfunction
  task automatic test_done();
    $display("Comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic wb(logic we, logic [7:0] a, logic [7:0] d,
                    logic [3:0] s = 4'h1);
    int k;
    @(posedge mclk);
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat_w, wb_sel} <=
      {2'b11, we, a, 24'h0, d, s};
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (wb_ack !== 1'b1 && k < 50);
    rd = wb_dat_r;
    {wb_cyc, wb_stb} <= 2'b00;
    if (k >= 50) errors++;
  endtask
  task automatic tx(logic [15:0] d);
    wb(1, `DBM_OFS_DHI, d[15:8]);
    wb(1, `DBM_OFS_DLO, d[7:0]);
  endtask
  // Polling the model only, so register traffic never disturbs a frame
  task automatic fr();
    int k;
    nx++;
    for (k = 0; k < 4000 && nfr < nx; k++) @(posedge mclk);
    if (k >= 4000) errors++;
    repeat (4) @(posedge mclk);
  endtask
  task automatic rresp(logic [15:0] d, logic e);
    wb(0, `DBM_OFS_STAT, 0);
    chk("status", rd & 32'h9, {e, 3'b001});
    wb(0, `DBM_OFS_DHI, 0);
    chk("data high", rd, d[15:8]);
    wb(0, `DBM_OFS_DLO, 0);
    chk("data low", rd, d[7:0]);
  endtask
  initial begin
    {arst_n, wb_we, wb_cyc, wb_stb, corrupt, wb_adr, wb_dat_w, wb_sel} = '0;
    {third_cyc, lfsr, poly, seed} = {8'd9, 32'h0000_8878, 16'h010A};
    {errors, n_tests, nx} = '0;
    repeat (6) @(posedge mclk);
    arst_n <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      wb(0, ra[i], 0);
      chk("reset value", rd, rv[i]);
    end
    wb(1, `DBM_OFS_POLY, 8'h5A, 4'h0);
    wb(0, `DBM_OFS_POLY, 0);
    chk("masked write", rd, 8'h01);
    wb(1, `DBM_OFS_CTRL, 8'h13);
    tx(16'h0000);
    fr();
    chk("zero frame", cap, 24'h00_000A);
    chk("frame bits", cap_n, 12);
    chk("bit period", period, 27);
    chk("enable", bus_en, 1);
    chk("rx irq", irq_oe, 1);
    chk("irq level", irq_drive, 0);
    rresp(0, 1);
    chk("rx irq clear", irq_oe, 0);
    wb(0, `DBM_OFS_STAT, 0);
    chk("popped", rd[0], 0);
    for (int k = 0; k < 5; k++) begin
      // Corners first: no check bits, then the longest word and check
      wl = (k == 1) ? 16 : 8 + rnd() % 9;
      cl = (k == 0) ? 0 : (k == 1) ? 8 : rnd() % 9;
      poly = rnd();
      seed = rnd();
      wb(1, `DBM_OFS_LEN, {4'(wl - 8), 4'(cl)});
      wb(1, `DBM_OFS_POLY, poly);
      wb(1, `DBM_OFS_SEED, seed);
      x = 16'(rnd() & ((32'h1 << wl) - 1));
      y = 16'(rnd() & ((32'h1 << wl) - 1));
      tx(x);
      fr();
      chk("frame", cap, frame(x, wl, cl));
      wb(0, `DBM_OFS_DLO, 0);
      tx(y);
      fr();
      chk("frame", cap, frame(y, wl, cl));
      rresp(x, 0);
      corrupt <= 1'b1;
      tx(x);
      fr();
      corrupt <= 1'b0;
      rresp(cl != 0 ? y : y ^ 16'h1, cl != 0);
    end
    wb(1, `DBM_OFS_CTRL, 8'h14);
    for (int i = 0; i < 5; i++) begin
      w[i] = 16'(rnd() & ((32'h1 << wl) - 1));
      tx(w[i]);
    end
    wb(0, `DBM_OFS_STAT, 0);
    chk("tx full", rd[2:1], 2'b00);
    chk("disabled", {bus_en, bus_frame_n, 30'(nfr)}, {2'b01, 30'(nx)});
    wb(1, `DBM_OFS_CTRL, 8'h15);
    for (int i = 0; i < 4; i++) begin
      fr();
      chk("queued frame", cap, frame(w[i], wl, cl));
    end
    chk("tx irq", irq_oe, 1);
    rresp(x, 0);
    for (int i = 0; i < 3; i++) rresp(w[i], 0);
    chk("no fifth", nfr, nx);
    for (int i = 0; i < 3; i++) begin
      third_cyc <= (i == 0) ? 8'd18 : (i == 1) ? 8'd11 : 8'd8;
      if (i == 2) wb(1, `DBM_OFS_OFFS, 8'hC0);
      wb(1, `DBM_OFS_CTRL, i ? 8'h29 : 8'h21);
      tx(w[4]);
      fr();
      chk("rate", period, (i == 0) ? 54 : (i == 1) ? 33 : 24);
      chk("rate frame", cap, frame(w[4], wl, cl));
      wb(0, `DBM_OFS_DLO, 0);
    end
    tx(w[4]);
    for (t = 0; t < 4000 && bus_frame_n !== 1'b0; t++) @(posedge mclk);
    if (t >= 4000) errors++;
    arst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    chk("reset pins", {bus_frame_n, bus_sig, bus_en, irq_oe}, 4'hC);
    arst_n <= 1'b1;
    repeat (300) @(posedge mclk);
    chk("halted", nfr, 0);
    wb(0, `DBM_OFS_CTRL, 0);
    chk("ctrl reset", rd, 8'h10);
    wb(0, `DBM_OFS_STAT, 0);
    chk("queues reset", rd, 8'h06);
    test_done();
  end
  initial begin
    #(40000 * 4);
    errors++;
    test_done();
  end
endmodule // dual_bus_master_crc_fifo_tb
